/* File: gpio_pkg.sv */
// Package for the three-port general-purpose I/O block.
// Assumes a single 100 MHz clock and a plain strobed register port.
package gpio_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_P7_LATCH = 12'h007;
    localparam logic [11:0] OFS_P8_LATCH = 12'h008;
    localparam logic [11:0] OFS_P9_LATCH = 12'h009;
    localparam logic [11:0] OFS_P7_PIN_READ = 12'h014;
    localparam logic [11:0] OFS_P8_PIN_READ = 12'h015;
    localparam logic [11:0] OFS_P9_PIN_READ = 12'h016;
    localparam logic [11:0] OFS_P7_DIR = 12'hf21;
    localparam logic [11:0] OFS_P8_DIR = 12'hf22;
    localparam logic [11:0] OFS_P9_DIR = 12'hf23;
    localparam logic [11:0] OFS_P9_PULLUP = 12'hf30;
    localparam logic [11:0] OFS_P7_FUNC = 12'hf3b;
    localparam logic [11:0] OFS_P8_FUNC = 12'hf3c;
    localparam logic [11:0] OFS_P9_FUNC = 12'hf3d;
    localparam logic [11:0] OFS_P9_OPEN_DRAIN = 12'hf4a;
    // Writable bit masks; other bits read zero
    localparam logic [7:0] MASK_P7 = 8'hff;
    localparam logic [7:0] MASK_P7_FUNC = 8'h1f;
    localparam logic [7:0] MASK_P8 = 8'h0f;
    localparam logic [7:0] MASK_P8_FUNC = 8'h03;
    localparam logic [7:0] MASK_P9 = 8'h03;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam int unsigned P7_W = 8;
    localparam int unsigned P8_W = 4;
    localparam int unsigned P9_W = 2;
endpackage

/* File: gpio_pin_cell.sv */
// One push-pull pin: direction, function mux, input gating.
// Assumes inputs synchronous to clk; output taken from a flip-flop.
`timescale 1ns/1ps
module gpio_pin_cell (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Settings
    input wire logic latch_bit,
    input wire logic dir_bit,
    input wire logic func_bit,
    input wire logic periph_out,
    // Pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // Read-back and peripheral input
    output logic read_bit,
    output logic periph_in
);
    typedef struct packed {
        logic out;
        logic oe;
    } cell_t;
    cell_t cell_ff;
    cell_t nxt_cell;

    always_comb begin
        nxt_cell = cell_ff;
        nxt_cell.out = func_bit ? periph_out : latch_bit;
        nxt_cell.oe = dir_bit;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cell_ff <= '0;
        end else if (ce) begin
            cell_ff <= nxt_cell;
        end
    end

    assign pin_out = cell_ff.out;
    assign pin_oe = cell_ff.oe;
    assign read_bit = dir_bit ? 1'b0 : pin_in;
    assign periph_in = dir_bit ? 1'b0 : pin_in;
endmodule

/* File: gpio_od_cell.sv */
// One port-9 pin with open-drain option and pull-up control.
// Assumes the pad applies the pull-up when pullup_en is high.
`timescale 1ns/1ps
module gpio_od_cell (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Settings
    input wire logic latch_bit,
    input wire logic dir_bit,
    input wire logic func_bit,
    input wire logic od_bit,
    input wire logic pu_bit,
    input wire logic periph_out,
    // Pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pullup_en,
    // Read-back and peripheral input
    output logic read_bit,
    output logic periph_in
);
    typedef struct packed {
        logic out;
        logic oe;
        logic pu;
    } cell_t;
    cell_t cell_ff;
    cell_t nxt_cell;
    logic level;

    always_comb begin
        nxt_cell = cell_ff;
        level = func_bit ? periph_out : latch_bit;
        if (od_bit) begin
            nxt_cell.out = 1'b0;
            nxt_cell.oe = dir_bit & ~level;
        end else begin
            nxt_cell.out = level;
            nxt_cell.oe = dir_bit;
        end
        nxt_cell.pu = pu_bit & (~dir_bit | od_bit);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cell_ff <= '0;
        end else if (ce) begin
            cell_ff <= nxt_cell;
        end
    end

    assign pin_out = cell_ff.out;
    assign pin_oe = cell_ff.oe;
    assign pullup_en = cell_ff.pu;
    // Open-drain output still reads the wire level
    assign read_bit = (~dir_bit | od_bit) ? pin_in : 1'b0;
    assign periph_in = (~dir_bit | od_bit) ? pin_in : 1'b1;
endmodule

/* File: gpio_ports.sv */
// Top of ports 7, 8 and 9 with the register port.
// Assumes inputs synchronous to clk; read data one cycle after strobe.
`timescale 1ns/1ps
module gpio_ports (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Port 7 pins
    input wire logic [7:0] p7_in,
    output logic [7:0] p7_out,
    output logic [7:0] p7_oe,
    // Port 8 pins
    input wire logic [3:0] p8_in,
    output logic [3:0] p8_out,
    output logic [3:0] p8_oe,
    // Port 9 pins
    input wire logic [1:0] p9_in,
    output logic [1:0] p9_out,
    output logic [1:0] p9_oe,
    output logic [1:0] p9_pullup_en,
    // Port 7 peripherals
    output logic ext_irq_in_a,
    output logic ext_irq_in_b,
    output logic ext_irq_in_c,
    input wire logic divider_out,
    input wire logic pulse_gen_b_out0,
    input wire logic pulse_gen_b_out1,
    output logic timer_b_in0,
    output logic timer_b_in1,
    input wire logic pulse_gen_a_out0,
    input wire logic pulse_gen_a_out1,
    input wire logic pwm_a_out0,
    input wire logic pwm_a_out1,
    input wire logic pwm_a_sel01,
    output logic timer_a_in0,
    output logic timer_a_in1,
    // Port 8 peripherals
    input wire logic pulse_gen_a_out2,
    input wire logic pulse_gen_a_out3,
    input wire logic pwm_a_out2,
    input wire logic pwm_a_out3,
    input wire logic pwm_a_sel23,
    output logic timer_a_in2,
    output logic timer_a_in3,
    // Port 9 serial
    input wire logic [1:0] uart_tx,
    output logic [1:0] uart_rx
);
    typedef struct packed {
        logic [7:0] p7_latch;
        logic [7:0] p7_dir;
        logic [7:0] p7_func;
        logic [7:0] p8_latch;
        logic [7:0] p8_dir;
        logic [7:0] p8_func;
        logic [7:0] p9_latch;
        logic [7:0] p9_dir;
        logic [7:0] p9_func;
        logic [7:0] p9_od;
        logic [7:0] p9_pu;
        logic [7:0] rdata;
        logic [7:0] p7_per_in;
        logic [3:0] p8_per_in;
        logic [1:0] p9_per_in;
    } state_t;
    state_t st_ff;
    state_t nxt_st;

    logic [7:0] p7_rd;
    logic [7:0] p7_pin_in;
    logic [7:0] p7_per_out;
    logic [3:0] p8_rd;
    logic [3:0] p8_pin_in;
    logic [3:0] p8_per_out;
    logic [1:0] p9_rd;
    logic [1:0] p9_pin_in;

    assign p7_per_out = {3'h0, divider_out, pulse_gen_b_out1,
        pulse_gen_b_out0,
        pwm_a_sel01 ? pwm_a_out1 : pulse_gen_a_out1,
        pwm_a_sel01 ? pwm_a_out0 : pulse_gen_a_out0};
    assign p8_per_out = {2'h0,
        pwm_a_sel23 ? pwm_a_out3 : pulse_gen_a_out3,
        pwm_a_sel23 ? pwm_a_out2 : pulse_gen_a_out2};

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_p7
            gpio_pin_cell u_cell (
                .clk(clk),
                .rstn(rstn),
                .ce(ce),
                .latch_bit(st_ff.p7_latch[i]),
                .dir_bit(st_ff.p7_dir[i]),
                .func_bit(st_ff.p7_func[i]),
                .periph_out(p7_per_out[i]),
                .pin_in(p7_in[i]),
                .pin_out(p7_out[i]),
                .pin_oe(p7_oe[i]),
                .read_bit(p7_rd[i]),
                .periph_in(p7_pin_in[i])
            );
        end
        for (i = 0; i < 4; i++) begin : g_p8
            gpio_pin_cell u_cell (
                .clk(clk),
                .rstn(rstn),
                .ce(ce),
                .latch_bit(st_ff.p8_latch[i]),
                .dir_bit(st_ff.p8_dir[i]),
                .func_bit(st_ff.p8_func[i]),
                .periph_out(p8_per_out[i]),
                .pin_in(p8_in[i]),
                .pin_out(p8_out[i]),
                .pin_oe(p8_oe[i]),
                .read_bit(p8_rd[i]),
                .periph_in(p8_pin_in[i])
            );
        end
        for (i = 0; i < 2; i++) begin : g_p9
            gpio_od_cell u_cell (
                .clk(clk),
                .rstn(rstn),
                .ce(ce),
                .latch_bit(st_ff.p9_latch[i]),
                .dir_bit(st_ff.p9_dir[i]),
                .func_bit(st_ff.p9_func[i]),
                .od_bit(st_ff.p9_od[i]),
                .pu_bit(st_ff.p9_pu[i]),
                .periph_out(uart_tx[i]),
                .pin_in(p9_in[i]),
                .pin_out(p9_out[i]),
                .pin_oe(p9_oe[i]),
                .pullup_en(p9_pullup_en[i]),
                .read_bit(p9_rd[i]),
                .periph_in(p9_pin_in[i])
            );
        end
    endgenerate

    always_comb begin
        nxt_st = st_ff;
        nxt_st.p7_per_in = p7_pin_in;
        nxt_st.p8_per_in = p8_pin_in;
        nxt_st.p9_per_in = p9_pin_in;
        if (wr) begin
            case (addr)
                gpio_pkg::OFS_P7_LATCH: nxt_st.p7_latch = wdata;
                gpio_pkg::OFS_P7_DIR: nxt_st.p7_dir = wdata;
                gpio_pkg::OFS_P7_FUNC:
                    nxt_st.p7_func = wdata & gpio_pkg::MASK_P7_FUNC;
                gpio_pkg::OFS_P8_LATCH:
                    nxt_st.p8_latch = wdata & gpio_pkg::MASK_P8;
                gpio_pkg::OFS_P8_DIR:
                    nxt_st.p8_dir = wdata & gpio_pkg::MASK_P8;
                gpio_pkg::OFS_P8_FUNC:
                    nxt_st.p8_func = wdata & gpio_pkg::MASK_P8_FUNC;
                gpio_pkg::OFS_P9_LATCH:
                    nxt_st.p9_latch = wdata & gpio_pkg::MASK_P9;
                gpio_pkg::OFS_P9_DIR:
                    nxt_st.p9_dir = wdata & gpio_pkg::MASK_P9;
                gpio_pkg::OFS_P9_FUNC:
                    nxt_st.p9_func = wdata & gpio_pkg::MASK_P9;
                gpio_pkg::OFS_P9_OPEN_DRAIN:
                    nxt_st.p9_od = wdata & gpio_pkg::MASK_P9;
                gpio_pkg::OFS_P9_PULLUP:
                    nxt_st.p9_pu = wdata & gpio_pkg::MASK_P9;
                default: ;
            endcase
        end
        if (rd) begin
            case (addr)
                gpio_pkg::OFS_P7_LATCH: nxt_st.rdata = st_ff.p7_latch;
                gpio_pkg::OFS_P7_DIR: nxt_st.rdata = st_ff.p7_dir;
                gpio_pkg::OFS_P7_FUNC: nxt_st.rdata = st_ff.p7_func;
                gpio_pkg::OFS_P7_PIN_READ: nxt_st.rdata = p7_rd;
                gpio_pkg::OFS_P8_LATCH: nxt_st.rdata = st_ff.p8_latch;
                gpio_pkg::OFS_P8_DIR: nxt_st.rdata = st_ff.p8_dir;
                gpio_pkg::OFS_P8_FUNC: nxt_st.rdata = st_ff.p8_func;
                gpio_pkg::OFS_P8_PIN_READ: nxt_st.rdata = {4'h0, p8_rd};
                gpio_pkg::OFS_P9_LATCH: nxt_st.rdata = st_ff.p9_latch;
                gpio_pkg::OFS_P9_DIR: nxt_st.rdata = st_ff.p9_dir;
                gpio_pkg::OFS_P9_FUNC: nxt_st.rdata = st_ff.p9_func;
                gpio_pkg::OFS_P9_OPEN_DRAIN: nxt_st.rdata = st_ff.p9_od;
                gpio_pkg::OFS_P9_PULLUP: nxt_st.rdata = st_ff.p9_pu;
                gpio_pkg::OFS_P9_PIN_READ: nxt_st.rdata = {6'h00, p9_rd};
                default: nxt_st.rdata = 8'h00;
            endcase
        end else begin
            // Data stand only in the cycle after the read
            nxt_st.rdata = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.rdata;
    assign ext_irq_in_c = st_ff.p7_per_in[7];
    assign ext_irq_in_b = st_ff.p7_per_in[6];
    assign ext_irq_in_a = st_ff.p7_per_in[5];
    assign timer_b_in1 = st_ff.p7_per_in[3];
    assign timer_b_in0 = st_ff.p7_per_in[2];
    assign timer_a_in1 = st_ff.p7_per_in[1];
    assign timer_a_in0 = st_ff.p7_per_in[0];
    assign timer_a_in3 = st_ff.p8_per_in[1];
    assign timer_a_in2 = st_ff.p8_per_in[0];
    assign uart_rx = st_ff.p9_per_in;
endmodule

/* File: gpio_ports_chk.sv */
// Assertions on pins and read data of the three-port I/O block.
// Assumes ce stays high around direction writes and pin reads.
`timescale 1ns/1ps
module gpio_ports_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Pins and peripheral inputs
    input wire logic [7:0] p7_in,
    input wire logic [7:0] p7_out,
    input wire logic [7:0] p7_oe,
    input wire logic [3:0] p8_in,
    input wire logic [3:0] p8_out,
    input wire logic [3:0] p8_oe,
    input wire logic ext_irq_in_a,
    input wire logic timer_a_in2
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_wr(logic [11:0] a);
        wr && addr == a;
    endsequence
    sequence s_rd(logic [11:0] a);
        rd && addr == a;
    endsequence
    // Read gated by a settled direction, so a fresh write is skipped
    chk_p7_pin_read: assert property (
        s_rd(gpio_pkg::OFS_P7_PIN_READ) ##1 $stable(p7_oe)
        |-> rdata == ($past(p7_in) & ~$past(p7_oe)))
        else $error("p7 pin read wrong");
    chk_p8_pin_read: assert property (
        s_rd(gpio_pkg::OFS_P8_PIN_READ) ##1 $stable(p8_oe)
        |-> rdata == {4'h0, $past(p8_in) & ~$past(p8_oe)})
        else $error("p8 pin read wrong");
    chk_p7_dir_oe: assert property (
        s_wr(gpio_pkg::OFS_P7_DIR) |-> ##2 p7_oe == $past(wdata, 2))
        else $error("p7 enable does not follow direction");
    chk_p8_dir_oe: assert property (
        s_wr(gpio_pkg::OFS_P8_DIR)
        |-> ##2 {4'h0, p8_oe} == ($past(wdata, 2) & 8'h0f))
        else $error("p8 enable does not follow direction");
    chk_p7_latch_drive: assert property (
        s_wr(gpio_pkg::OFS_P7_LATCH) ##2 p7_oe[7]
        |-> p7_out[7] == $past(wdata[7], 2))
        else $error("p7 bit 7 level wrong");
    chk_p8_plain_drive: assert property (
        s_wr(gpio_pkg::OFS_P8_LATCH) ##2 p8_oe[3]
        |-> p8_out[3] == $past(wdata[3], 2))
        else $error("p8 bit 3 level wrong");
    chk_irq_follow: assert property (
        !p7_oe[5] [*3] |-> ext_irq_in_a == $past(p7_in[5]))
        else $error("interrupt input does not follow pin");
    chk_irq_blocked: assert property (
        p7_oe[5] [*3] |-> !ext_irq_in_a)
        else $error("interrupt input seen in output mode");
    chk_timer_blocked: assert property (
        p8_oe[0] [*3] |-> !timer_a_in2)
        else $error("timer input seen in output mode");
endmodule
bind gpio_ports gpio_ports_chk u_chk (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .p7_in(p7_in), .p7_out(p7_out), .p7_oe(p7_oe), .p8_in(p8_in),
    .p8_out(p8_out), .p8_oe(p8_oe), .ext_irq_in_a(ext_irq_in_a),
    .timer_a_in2(timer_a_in2));

/* File: pin_env.sv */
// Board side of the pins: a driven pin shows the block's level.
// Assumes the testbench holds the board levels of undriven pins.
`timescale 1ns/1ps
module pin_env (
    // From the block
    input wire logic [7:0] p7_out,
    input wire logic [7:0] p7_oe,
    input wire logic [3:0] p8_out,
    input wire logic [3:0] p8_oe,
    input wire logic [1:0] p9_out,
    input wire logic [1:0] p9_oe,
    input wire logic [1:0] p9_pullup_en,
    // Board levels
    input wire logic [7:0] p7_ext,
    input wire logic [3:0] p8_ext,
    input wire logic [1:0] p9_ext,
    // To the block
    output logic [7:0] p7_in,
    output logic [3:0] p8_in,
    output logic [1:0] p9_in
);
    assign p7_in = (p7_oe & p7_out) | (~p7_oe & p7_ext);
    assign p8_in = (p8_oe & p8_out) | (~p8_oe & p8_ext);
    // Released pin rises if the pull-up is on, whatever the board says
    assign p9_in = (p9_oe & p9_out) | (~p9_oe & (p9_pullup_en | p9_ext));
endmodule

/* File: tb_top.sv */
// Self-checking bench for the three-port I/O block.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [12:0] per = 13'h0000;
    logic [1:0] uart_tx = 2'b00;
    logic [7:0] p7_ext = 8'h00;
    logic [3:0] p8_ext = 4'h0;
    logic [1:0] p9_ext = 2'b00;
    logic [7:0] rdata, p7_in, p7_out, p7_oe;
    logic [3:0] p8_in, p8_out, p8_oe;
    logic [1:0] p9_in, p9_out, p9_oe, p9_pullup_en, uart_rx;
    logic [2:0] irq;
    logic [5:0] tmr;
    int n_errors = 0;
    int checks_done = 0;
    row_t rows [9] = '{'{gpio_pkg::OFS_P7_LATCH, 8'hff, 8'hff},
        '{gpio_pkg::OFS_P8_LATCH, 8'hff, 8'h0f},
        '{gpio_pkg::OFS_P7_DIR, 8'h3c, 8'h3c},
        '{gpio_pkg::OFS_P8_DIR, 8'hff, 8'h0f},
        '{gpio_pkg::OFS_P7_FUNC, 8'hff, 8'h1f},
        '{gpio_pkg::OFS_P8_FUNC, 8'hff, 8'h03},
        '{gpio_pkg::OFS_P9_DIR, 8'hff, 8'h03},
        '{gpio_pkg::OFS_P9_LATCH, 8'hff, 8'h03},
        '{12'h0ff, 8'hff, 8'h00}};
    always #5 clk = ~clk;
    gpio_ports u_gpio_ports (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .p7_in(p7_in),
        .p7_out(p7_out), .p7_oe(p7_oe), .p8_in(p8_in), .p8_out(p8_out),
        .p8_oe(p8_oe), .p9_in(p9_in), .p9_out(p9_out), .p9_oe(p9_oe),
        .p9_pullup_en(p9_pullup_en), .ext_irq_in_a(irq[0]),
        .ext_irq_in_b(irq[1]), .ext_irq_in_c(irq[2]), .divider_out(per[0]),
        .pulse_gen_b_out0(per[1]), .pulse_gen_b_out1(per[2]),
        .timer_b_in0(tmr[0]), .timer_b_in1(tmr[1]),
        .pulse_gen_a_out0(per[3]), .pulse_gen_a_out1(per[4]),
        .pwm_a_out0(per[5]), .pwm_a_out1(per[6]), .pwm_a_sel01(per[7]),
        .timer_a_in0(tmr[2]), .timer_a_in1(tmr[3]),
        .pulse_gen_a_out2(per[8]), .pulse_gen_a_out3(per[9]),
        .pwm_a_out2(per[10]), .pwm_a_out3(per[11]), .pwm_a_sel23(per[12]),
        .timer_a_in2(tmr[4]), .timer_a_in3(tmr[5]), .uart_tx(uart_tx),
        .uart_rx(uart_rx));
    pin_env u_pin_env (.p7_out(p7_out), .p7_oe(p7_oe), .p8_out(p8_out),
        .p8_oe(p8_oe), .p9_out(p9_out), .p9_oe(p9_oe),
        .p9_pullup_en(p9_pullup_en), .p7_ext(p7_ext), .p8_ext(p8_ext),
        .p9_ext(p9_ext), .p7_in(p7_in), .p8_in(p8_in), .p9_in(p9_in));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // Pins lag a write by two edges; three leaves margin for inputs
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #50us;
        n_errors++;
        $display("Error at %0t: run hung", $time);
        stop_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[i]) rd_chk(rows[i].a, 8'h00);
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        $display("register rows done");
        wr_reg(gpio_pkg::OFS_P7_FUNC, 8'h00);
        wr_reg(gpio_pkg::OFS_P8_FUNC, 8'h00);
        wr_reg(gpio_pkg::OFS_P7_LATCH, 8'h5a);
        p7_ext <= 8'h99;
        p8_ext <= 4'hc;
        wr_reg(gpio_pkg::OFS_P7_DIR, 8'hf0);
        wr_reg(gpio_pkg::OFS_P8_LATCH, 8'h06);
        wr_reg(gpio_pkg::OFS_P8_DIR, 8'h03);
        settle();
        chk(p7_oe, 8'hf0);
        chk(p7_out & p7_oe, 8'h50);
        chk({p8_oe, p8_out & p8_oe}, 8'h32);
        rd_chk(gpio_pkg::OFS_P7_PIN_READ, 8'h09);
        rd_chk(gpio_pkg::OFS_P8_PIN_READ, 8'h0c);
        wr_reg(gpio_pkg::OFS_P7_PIN_READ, 8'hff);
        rd_chk(gpio_pkg::OFS_P7_PIN_READ, 8'h09);
        $display("latch and pin read done");
        per <= 13'h0933;
        wr_reg(gpio_pkg::OFS_P7_DIR, 8'hff);
        wr_reg(gpio_pkg::OFS_P7_FUNC, 8'h1f);
        wr_reg(gpio_pkg::OFS_P8_DIR, 8'h0f);
        wr_reg(gpio_pkg::OFS_P8_FUNC, 8'h03);
        settle();
        chk(p7_out, 8'h56);
        chk({4'h0, p8_out}, 8'h05);
        per <= 13'h19b3;
        settle();
        chk(p7_out, 8'h55);
        chk({4'h0, p8_out}, 8'h06);
        $display("peripheral outputs done");
        p7_ext <= 8'hac;
        p8_ext <= 4'h1;
        wr_reg(gpio_pkg::OFS_P7_DIR, 8'h00);
        wr_reg(gpio_pkg::OFS_P8_DIR, 8'h00);
        settle();
        chk({2'b00, tmr}, 8'h13);
        chk({5'h00, irq}, 8'h05);
        $display("peripheral inputs done");
        uart_tx <= 2'b01;
        wr_reg(gpio_pkg::OFS_P9_FUNC, 8'h03);
        wr_reg(gpio_pkg::OFS_P9_PULLUP, 8'h03);
        settle();
        chk({p9_out, p9_oe, p9_pullup_en, uart_rx}, 8'h73);
        wr_reg(gpio_pkg::OFS_P9_OPEN_DRAIN, 8'h03);
        settle();
        chk({p9_out, p9_oe, p9_pullup_en, uart_rx}, 8'h2d);
        rd_chk(gpio_pkg::OFS_P9_PIN_READ, 8'h01);
        $display("serial port done");
        // Writes while the enable is low must be lost
        ce <= 1'b0;
        wr_reg(gpio_pkg::OFS_P7_LATCH, 8'h00);
        ce <= 1'b1;
        rd_chk(gpio_pkg::OFS_P7_LATCH, 8'h5a);
        $display("clock enable done");
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(p7_out, 8'h00);
        chk({p9_pullup_en, p9_oe, p8_oe}, 8'h00);
        rstn <= 1'b1;
        rd_chk(gpio_pkg::OFS_P9_DIR, 8'h00);
        $display("mid-run reset done");
        stop_test();
    end
endmodule
